// ---- inc/lpm_pkg.sv ----
package lpm_pkg;
   // Register word addresses on the plain register port.
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CLK = 4'h1;
   localparam logic [3:0] ADDR_MODE = 4'h2;
   localparam logic [3:0] ADDR_WMASK = 4'h3;
   localparam logic [3:0] ADDR_STAT = 4'h4;
   // Control register field positions.
   localparam int CTRL_RANGE = 0;
   localparam int CTRL_VREF = 2;
   localparam int CTRL_VAUTO = 3;
   localparam int CTRL_PVD_EN = 4;
   localparam int CTRL_PVD_LVL = 5;
   localparam int CTRL_PVD_FALL = 8;
   localparam int CTRL_PVD_RISE = 9;
   // Clock register field positions.
   localparam int CLK_SRC = 0;
   localparam int CLK_KHZ = 2;
   // Status write-one-to-clear position of the refusal flag.
   localparam int STAT_REFUSED = 0;
   // Core-voltage range codes; zero is not a legal range.
   localparam logic [1:0] RANGE_1 = 2'h1;
   localparam logic [1:0] RANGE_2 = 2'h2;
   localparam logic [1:0] RANGE_3 = 2'h3;
   localparam logic [1:0] RANGE_RST = 2'h2;
   // System clock sources.
   localparam logic [1:0] SRC_MSI = 2'h0;
   localparam logic [1:0] SRC_RST = 2'h0;
   // Clock frequency limits in kHz: 32000, 16000, 4000 and 131.
   localparam logic [15:0] LIM_R1_KHZ = 16'h7d00;
   localparam logic [15:0] LIM_R2_KHZ = 16'h3e80;
   localparam logic [15:0] LIM_R3_KHZ = 16'h0fa0;
   localparam logic [15:0] LPRUN_MAX_KHZ = 16'h0083;
   localparam logic [15:0] KHZ_RST = 16'h07d0;
   // Regulator modes.
   localparam logic [1:0] REG_MAIN = 2'h0;
   localparam logic [1:0] REG_LP = 2'h1;
   localparam logic [1:0] REG_PDN = 2'h2;
   // Boot sources.
   localparam logic [1:0] BOOT_FLASH = 2'h0;
   localparam logic [1:0] BOOT_SYSMEM = 2'h1;
   localparam logic [1:0] BOOT_RAM = 2'h2;
   // Mode request codes written to the mode register.
   localparam logic [2:0] MODE_RUN = 3'h0;
   localparam logic [2:0] MODE_SLEEP = 3'h1;
   localparam logic [2:0] MODE_LPRUN = 3'h2;
   localparam logic [2:0] MODE_STOP_RTC = 3'h3;
   localparam logic [2:0] MODE_STOP_NORTC = 3'h4;
   localparam logic [2:0] MODE_STANDBY = 3'h5;
   // Stop wakeup time and the cycle budget derived from it, rounded down.
   localparam int WAKE_MAX_NS = 8000;
   localparam int CLK_PERIOD_NS = 100;
   localparam int WAKE_CYC = WAKE_MAX_NS / CLK_PERIOD_NS;
   // Two synchroniser stages and two decision cycles come out of the budget.
   localparam logic [6:0] WAKE_HOLD = 7'(WAKE_CYC - 4);
   // Synchroniser vector layout.
   localparam int SY_EXT = 0;
   localparam int SY_COMP = 16;
   localparam int SY_RTC = 18;
   localparam int SY_USB = 22;
   localparam int SY_SUPPLY = 23;
   localparam int SY_POR = 24;
   localparam int SY_BOR = 25;
   localparam int SY_BOOT = 26;
   localparam int SY_W = 28;
   localparam int WM_W = 24;
   // Boot sampling happens once the pin synchroniser holds real samples.
   localparam logic [1:0] BOOT_SAMPLE = 2'h2;

   typedef enum logic [3:0] {
      ST_RUN, ST_LPRUN, ST_ENTER, ST_SLEEP, ST_LPSLEEP,
      ST_STOP_RTC, ST_STOP_NORTC, ST_STANDBY, ST_WAKING
   } lpm_state_t;

   typedef struct packed {
      lpm_state_t st;
      lpm_state_t tgt;
      logic [1:0] range;
      logic vref_en;
      logic vref_auto;
      logic pvd_en;
      logic [2:0] pvd_lvl;
      logic pvd_fall;
      logic pvd_rise;
      logic [1:0] src;
      logic [15:0] khz;
      logic [2:0] mode_req;
      logic [WM_W-1:0] wmask;
      logic refused;
      logic pend;
      logic [6:0] wcnt;
      logic [SY_W-1:0] s1;
      logic [SY_W-1:0] s2;
      logic pvd_prev;
      logic pvd_evt;
      logic [1:0] boot_wait;
      logic [1:0] boot_src;
      logic [2:0] bor_lvl;
      logic [31:0] rdata;
   } lpm_regs_t;
endpackage : lpm_pkg

// ---- hw/lpm_ctrl.sv ----
`timescale 1ns/1ps
module lpm_ctrl (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [3:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic irq_in,
   input wire logic [15:0] ext_lines_in,
   input wire logic [1:0] comp_evt_in,
   input wire logic [3:0] rtc_evt_in,
   input wire logic usb_wake_in,
   input wire logic supply_below_in,
   input wire logic por_low_in,
   input wire logic bor_low_in,
   input wire logic [1:0] boot_pins_in,
   input wire logic [2:0] bor_level_in,
   output logic cpu_clk_en_out,
   output logic periph_clk_en_out,
   output logic [3:0] fast_osc_en_out,
   output logic slow_osc_en_out,
   output logic [1:0] reg_mode_out,
   output logic vref_en_out,
   output logic [1:0] vos_range_out,
   output logic [1:0] sysclk_src_out,
   output logic [15:0] sysclk_khz_out,
   output logic pvd_en_out,
   output logic [2:0] pvd_level_out,
   output logic pvd_evt_out,
   output logic [2:0] bor_level_out,
   output logic core_reset_out,
   output logic [1:0] boot_src_out,
   output logic [1:0] loader_ports_out
);
   import lpm_pkg::*;

   lpm_regs_t q; // All registered state.
   lpm_regs_t d; // Next value of the state.
   logic in_stop; // Either stop mode.
   logic vref_on; // Reference actually powered.
   logic [WM_W-1:0] wake_vec; // Wake sources after gating.
   logic wake_any; // An enabled wake source is active.
   logic supply_low; // Synchronised supply-low indication.
   logic lprun_ok; // Current clock admits low-power run.
   logic clk_ok; // Written clock setting is within limits.
   logic rng_ok; // Written range can carry the current clock.
   logic mode_wr; // A mode request is being written.
   logic refuse; // A write or request is refused this cycle.
   logic [15:0] new_khz; // Frequency field of the written data.
   logic [1:0] new_src; // Source field of the written data.
   logic [1:0] new_rng; // Range field of the written data.

   // Highest clock that a range allows; an illegal code allows nothing.
   function automatic logic [15:0] khz_lim(input logic [1:0] r);
      case (r)
         RANGE_1: khz_lim = LIM_R1_KHZ;
         RANGE_2: khz_lim = LIM_R2_KHZ;
         RANGE_3: khz_lim = LIM_R3_KHZ;
         default: khz_lim = 16'h0000;
      endcase
   endfunction : khz_lim

   assign new_khz = wdata_in[CLK_KHZ +: 16];
   assign new_src = wdata_in[CLK_SRC +: 2];
   assign new_rng = wdata_in[CTRL_RANGE +: 2];
   assign mode_wr = wr_in && (addr_in == ADDR_MODE);
   assign in_stop = (q.st == ST_STOP_RTC) || (q.st == ST_STOP_NORTC);
   // The reference may be dropped for the whole stop period to save current.
   assign vref_on = q.vref_en && !(in_stop && q.vref_auto);
   assign supply_low = q.s2[SY_POR] || q.s2[SY_BOR];
   assign lprun_ok = (q.src == SRC_MSI) && (q.khz < LPRUN_MAX_KHZ);
   // A clock switch must fit the range, and the low-power run bound while in it.
   assign clk_ok = (new_khz <= khz_lim(q.range))
      && ((q.range != RANGE_3) || (new_src == SRC_MSI))
      && ((q.st != ST_LPRUN) || ((new_src == SRC_MSI) && (new_khz < LPRUN_MAX_KHZ)));
   // Dropping the range under a running fast clock would overclock the core.
   assign rng_ok = (q.khz <= khz_lim(new_rng))
      && ((new_rng != RANGE_3) || (q.src == SRC_MSI));
   // Comparator events only count while the reference feeds them.
   assign wake_vec = {q.s2[SY_USB], q.s2[SY_RTC +: 4],
      q.s2[SY_COMP +: 2] & {2{vref_on}}, q.pvd_evt, q.s2[SY_EXT +: 16]};
   assign wake_any = |(wake_vec & q.wmask);

   // Next-state logic for the whole block.
   always_comb begin
      d = q;
      refuse = 1'b0;
      // Pins cross into the clock domain through two stages.
      d.s1 = {boot_pins_in, bor_low_in, por_low_in, supply_below_in, usb_wake_in,
         rtc_evt_in, comp_evt_in, ext_lines_in};
      d.s2 = q.s1;
      // Detector crossings; a high comparator output means supply is below.
      d.pvd_prev = q.s2[SY_SUPPLY];
      d.pvd_evt = q.pvd_en && ((q.pvd_fall && q.s2[SY_SUPPLY] && !q.pvd_prev)
         || (q.pvd_rise && !q.s2[SY_SUPPLY] && q.pvd_prev));
      // Boot pins and option bytes are taken once, after the pins are synchronised.
      if (q.boot_wait != 2'h3) begin
         d.boot_wait = q.boot_wait + 2'h1;
      end
      if (q.boot_wait == BOOT_SAMPLE) begin
         d.bor_lvl = bor_level_in;
         if (!q.s2[SY_BOOT]) begin
            d.boot_src = BOOT_FLASH;
         end else if (q.s2[SY_BOOT + 1]) begin
            d.boot_src = BOOT_RAM;
         end else begin
            d.boot_src = BOOT_SYSMEM;
         end
      end
      // Register writes; a refused field keeps its old value.
      if (wr_in) begin
         case (addr_in)
            ADDR_CTRL: begin
               if (rng_ok) begin
                  d.range = new_rng;
               end else begin
                  refuse = 1'b1;
               end
               d.vref_en = wdata_in[CTRL_VREF];
               d.vref_auto = wdata_in[CTRL_VAUTO];
               d.pvd_en = wdata_in[CTRL_PVD_EN];
               d.pvd_lvl = wdata_in[CTRL_PVD_LVL +: 3];
               d.pvd_fall = wdata_in[CTRL_PVD_FALL];
               d.pvd_rise = wdata_in[CTRL_PVD_RISE];
            end
            ADDR_CLK: begin
               if (clk_ok) begin
                  d.src = new_src;
                  d.khz = new_khz;
               end else begin
                  refuse = 1'b1;
               end
            end
            ADDR_MODE: d.mode_req = wdata_in[2:0];
            ADDR_WMASK: d.wmask = wdata_in[WM_W-1:0];
            default: d.wmask = q.wmask;
         endcase
      end
      // Mode sequencing.
      unique case (q.st)
         ST_RUN, ST_LPRUN: begin
            if (mode_wr) begin
               unique case (wdata_in[2:0])
                  MODE_RUN: d.st = ST_RUN;
                  MODE_LPRUN: begin
                     if (lprun_ok) begin
                        d.st = ST_LPRUN;
                     end else begin
                        refuse = 1'b1;
                     end
                  end
                  MODE_SLEEP: begin
                     d.st = ST_ENTER;
                     d.tgt = (q.st == ST_LPRUN) ? ST_LPSLEEP : ST_SLEEP;
                  end
                  MODE_STOP_RTC: begin
                     d.st = ST_ENTER;
                     d.tgt = ST_STOP_RTC;
                  end
                  MODE_STOP_NORTC: begin
                     d.st = ST_ENTER;
                     d.tgt = ST_STOP_NORTC;
                  end
                  MODE_STANDBY: begin
                     d.st = ST_ENTER;
                     d.tgt = ST_STANDBY;
                  end
                  default: refuse = 1'b1;
               endcase
            end
         end
         ST_ENTER: begin
            // A wake seen since the request cancels the entry.
            if (q.pend || (irq_in && ((q.tgt == ST_SLEEP) || (q.tgt == ST_LPSLEEP)))) begin
               d.st = ST_RUN;
            end else begin
               d.st = q.tgt;
            end
         end
         ST_SLEEP, ST_LPSLEEP: begin
            // Peripherals still run here, so any of their events may end the nap.
            if (irq_in || wake_any || q.pend) begin
               d.st = ST_RUN;
            end
         end
         ST_STOP_RTC, ST_STOP_NORTC, ST_STANDBY: begin
            // The interrupt is not synchronised and has no clock here, so it cannot wake.
            if (wake_any || q.pend) begin
               d.st = ST_WAKING;
               d.wcnt = 7'h00;
            end
         end
         ST_WAKING: begin
            // Oscillators restart; the run state follows inside the budget.
            d.wcnt = q.wcnt + 7'h01;
            if (q.wcnt == WAKE_HOLD - 7'h01) begin
               d.st = ST_RUN;
            end
         end
      endcase
      // Wake latch: a new event wins over the clear made by a mode write.
      // Without it an event during the entry cycle would be lost in the deep state.
      d.pend = (q.pend && !mode_wr) || wake_any;
      // Refusal flag: set wins over the write-one clear.
      d.refused = refuse || (q.refused
         && !(wr_in && (addr_in == ADDR_STAT) && wdata_in[STAT_REFUSED]));
      // Read data stand in the cycle after the strobe; unmapped reads give zero.
      d.rdata = 32'h0000_0000;
      if (rd_in) begin
         case (addr_in)
            ADDR_CTRL: d.rdata = 32'({q.pvd_rise, q.pvd_fall, q.pvd_lvl, q.pvd_en,
               q.vref_auto, q.vref_en, q.range});
            ADDR_CLK: d.rdata = 32'({q.khz, q.src});
            ADDR_MODE: d.rdata = 32'(q.mode_req);
            ADDR_WMASK: d.rdata = 32'(q.wmask);
            ADDR_STAT: d.rdata = 32'({q.bor_lvl, q.boot_src, q.s2[SY_SUPPLY],
               reg_mode_out, q.st, q.pend, q.refused});
            default: d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // State register with synchronous reset to fixed constants.
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         q <= '0;
         q.range <= RANGE_RST;
         q.src <= SRC_RST;
         q.khz <= KHZ_RST;
      end else begin
         q <= d;
      end
   end

   // Outputs are decoded from registered state, except core_reset_out, which also follows rst_in directly.
   assign rdata_out = q.rdata;
   assign cpu_clk_en_out = (q.st == ST_RUN) || (q.st == ST_LPRUN) || (q.st == ST_ENTER);
   assign periph_clk_en_out = cpu_clk_en_out || (q.st == ST_SLEEP)
      || (q.st == ST_LPSLEEP);
   // Fast oscillators are all off in stop and standby.
   assign fast_osc_en_out = (in_stop || (q.st == ST_STANDBY)) ? 4'h0
      : 4'(4'h1 << q.src);
   assign slow_osc_en_out = (q.st != ST_STOP_NORTC);
   // Only standby powers down; low-power states use the small regulator.
   always_comb begin
      unique case (q.st)
         ST_STANDBY: reg_mode_out = REG_PDN;
         ST_LPRUN, ST_LPSLEEP, ST_STOP_RTC, ST_STOP_NORTC: reg_mode_out = REG_LP;
         ST_ENTER: reg_mode_out = (q.tgt == ST_LPSLEEP) ? REG_LP : REG_MAIN;
         default: reg_mode_out = REG_MAIN;
      endcase
   end
   assign vref_en_out = vref_on;
   assign vos_range_out = q.range;
   assign sysclk_src_out = q.src;
   assign sysclk_khz_out = q.khz;
   assign pvd_en_out = q.pvd_en;
   assign pvd_level_out = q.pvd_lvl;
   assign pvd_evt_out = q.pvd_evt;
   assign bor_level_out = q.bor_lvl;
   // Core logic is held in reset on low supply and while powered down.
   assign core_reset_out = rst_in || supply_low || (q.st == ST_STANDBY);
   assign boot_src_out = q.boot_src;
   assign loader_ports_out = (q.boot_src == BOOT_SYSMEM) ? 2'h3 : 2'h0;

   // Checks on the sequencing.
   // Every check runs on the one system clock and rests during reset.
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_stop_wake;
      (in_stop || (q.st == ST_STANDBY)) && wake_any;
   endsequence
   sequence s_lps_wake;
      (q.st == ST_LPSLEEP) && (irq_in || wake_any);
   endsequence
   sequence s_lp_sleep_req;
      (q.st == ST_LPRUN) && mode_wr && (wdata_in[2:0] == MODE_SLEEP);
   endsequence

   a_sleep_cpu_only: assert property ((q.st == ST_SLEEP)
      |-> !cpu_clk_en_out && periph_clk_en_out) else $error("sleep clock gating wrong");
   a_lpsleep_wake: assert property (s_lps_wake
      |=> (q.st == ST_RUN) && (reg_mode_out == REG_MAIN)) else $error("lp sleep wake wrong");
   a_stop_rtc_osc: assert property ((q.st == ST_STOP_RTC)
      |-> fast_osc_en_out == 4'h0 && slow_osc_en_out && reg_mode_out == REG_LP)
      else $error("stop with clock setup wrong");
   a_stop_nortc_osc: assert property ((q.st == ST_STOP_NORTC)
      |-> !slow_osc_en_out && fast_osc_en_out == 4'h0) else $error("stop oscillators on");
   a_stop_wake_time: assert property (s_stop_wake
      |=> (q.st == ST_WAKING) ##[1:77] (q.st == ST_RUN)) else $error("stop wake too slow");
   a_run_main_reg: assert property ((q.st == ST_RUN) |-> reg_mode_out == REG_MAIN)
      else $error("run without main regulator");
   a_lprun_clock: assert property ((q.st == ST_LPRUN)
      |-> q.src == SRC_MSI && q.khz < LPRUN_MAX_KHZ && reg_mode_out == REG_LP)
      else $error("low-power run setup wrong");
   a_standby_pdn: assert property ((q.st == ST_STANDBY)
      |-> reg_mode_out == REG_PDN && slow_osc_en_out && core_reset_out)
      else $error("standby setup wrong");
   a_supply_reset: assert property (supply_low |-> core_reset_out)
      else $error("core not reset on low supply");
   a_entry_abort: assert property ((q.st == ST_ENTER) && q.pend |=> q.st == ST_RUN)
      else $error("pending wake did not abort entry");
   a_clock_limit: assert property ((sysclk_khz_out <= khz_lim(vos_range_out))
      && ((vos_range_out != RANGE_3) || (sysclk_src_out == SRC_MSI)))
      else $error("clock over range limit");
   a_pvd_fall_evt: assert property (q.pvd_en && q.pvd_fall && $rose(q.s2[SY_SUPPLY])
      |=> pvd_evt_out) else $error("missing falling supply event");
   a_vref_auto: assert property (in_stop && q.vref_auto |-> !vref_en_out)
      else $error("reference on during stop");

   // With no live source the stop state must hold, so masked pins stay quiet.
   a_stop_hold: assert property (in_stop && !wake_any && !q.pend
      |=> $stable(q.st)) else $error("stop left without wake source");

   // Option-byte level and boot choice are frozen once taken.
   a_boot_hold: assert property ((q.boot_wait == 2'h3)
      |=> $stable(boot_src_out) && $stable(bor_level_out)) else $error("boot choice moved");

   // A rising supply is a crossing too, when chosen.
   a_pvd_rise_evt: assert property (q.pvd_en && q.pvd_rise && $fell(q.s2[SY_SUPPLY])
      |=> pvd_evt_out) else $error("missing rising supply event");

   // A disabled detector never reports, whatever the supply does.
   a_pvd_off_quiet: assert property (!q.pvd_en |=> !pvd_evt_out)
      else $error("detector event while off");

   // Sleep asked from low-power run ends in low-power sleep unless a wake aborts it.
   a_lpsleep_entry: assert property (s_lp_sleep_req
      |=> (q.st == ST_ENTER) ##1 ((q.st == ST_LPSLEEP) || (q.st == ST_RUN)))
      else $error("low-power sleep entry wrong");

   // An interrupt alone ends plain sleep on the next cycle.
   a_sleep_irq_wake: assert property ((q.st == ST_SLEEP) && irq_in |=> q.st == ST_RUN)
      else $error("interrupt did not wake sleep");

   // A refusal must leave its mark in the status flag.
   a_refused_sticky: assert property (refuse |=> q.refused)
      else $error("refusal not flagged");

   // The core stays unclocked until the oscillators are back.
   a_waking_cpu_off: assert property ((q.st == ST_WAKING) |-> !cpu_clk_en_out)
      else $error("core clocked while waking");

   // An interrupt during a sleep entry sends the core back to run.
   a_abort_irq: assert property ((q.st == ST_ENTER) && irq_in
      && (q.tgt == ST_SLEEP) |=> q.st == ST_RUN) else $error("interrupt did not abort sleep");
endmodule : lpm_ctrl

// ---- dv/lpm_far_model.sv ----
`timescale 1ns/1ps
// Far side of the controller: processor interrupt, wakeup sources and supply monitors.
// Every source idles low, as the released event lines are pulled down.
module lpm_far_model (
   input wire logic sys_clk_in,
   output logic irq_out,
   output logic [15:0] ext_lines_out,
   output logic [1:0] comp_evt_out,
   output logic [3:0] rtc_evt_out,
   output logic usb_wake_out,
   output logic supply_below_out,
   output logic por_low_out,
   output logic bor_low_out
);
   // All sources start quiet so nothing wakes the block by accident.
   initial begin
      irq_out = 1'b0;
      ext_lines_out = 16'h0000;
      comp_evt_out = 2'h0;
      rtc_evt_out = 4'h0;
      usb_wake_out = 1'b0;
      supply_below_out = 1'b0;
      por_low_out = 1'b0;
      bor_low_out = 1'b0;
   end

   // Sets one source after a rising edge; codes 0..15 are event lines.
   task automatic level(input int src, input logic v);
      @(posedge sys_clk_in);
      if (src < 16) begin
         ext_lines_out[src[3:0]] <= v;
      end else begin
         case (src)
            16: irq_out <= v;
            17: usb_wake_out <= v;
            18: rtc_evt_out[0] <= v;
            19: supply_below_out <= v;
            20: bor_low_out <= v;
            22: comp_evt_out[0] <= v;
            default: por_low_out <= v;
         endcase
      end
   endtask : level

   // Holds a source high for a few cycles, long enough for the synchroniser.
   task automatic pulse(input int src, input int n);
      level(src, 1'b1);
      repeat (n - 1) @(posedge sys_clk_in);
      level(src, 1'b0);
   endtask : pulse
endmodule : lpm_far_model

// ---- dv/lpm_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module lpm_ctrl_tb_top;
   import lpm_pkg::*;
   // One register-port step with the range, speed and source expected after it.
   typedef struct packed {
      logic [3:0] a;
      logic [17:0] d;
      logic [1:0] er;
      logic [15:0] ek;
      logic [1:0] es;
   } lpm_step_t;
   logic sys_clk_in, rst_in, wr_in, rd_in, irq, usb, sup, por, bor;
   logic [3:0] addr_in, rtc, fast_en;
   logic [31:0] wdata_in, rdata_out, rd_v;
   logic [1:0] boot_pins_in, comp, reg_mode, vos, src, boot_src, ldr;
   logic [2:0] bor_level_in, pvd_lvl, bor_lvl;
   logic [15:0] ext, khz;
   logic cpu_en, per_en, slow_en, vref_en, pvd_en, pvd_evt, core_rst;
   int num_errors, n_tests, cyc, t0, hits, k;
   lpm_step_t steps [12];

   lpm_ctrl DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .irq_in(irq), .ext_lines_in(ext), .comp_evt_in(comp), .rtc_evt_in(rtc),
      .usb_wake_in(usb), .supply_below_in(sup), .por_low_in(por), .bor_low_in(bor),
      .boot_pins_in(boot_pins_in), .bor_level_in(bor_level_in), .cpu_clk_en_out(cpu_en),
      .periph_clk_en_out(per_en), .fast_osc_en_out(fast_en), .slow_osc_en_out(slow_en),
      .reg_mode_out(reg_mode), .vref_en_out(vref_en), .vos_range_out(vos),
      .sysclk_src_out(src), .sysclk_khz_out(khz), .pvd_en_out(pvd_en),
      .pvd_level_out(pvd_lvl), .pvd_evt_out(pvd_evt), .bor_level_out(bor_lvl),
      .core_reset_out(core_rst), .boot_src_out(boot_src), .loader_ports_out(ldr));

   lpm_far_model far (.sys_clk_in(sys_clk_in), .irq_out(irq), .ext_lines_out(ext),
      .comp_evt_out(comp), .rtc_evt_out(rtc), .usb_wake_out(usb),
      .supply_below_out(sup), .por_low_out(por), .bor_low_out(bor));

   // Free-running 100 ns clock.
   initial begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end

   // Cycle count for timing checks; the ceiling cuts a hang short.
   always @(posedge sys_clk_in) begin
      cyc++;
      if (pvd_evt === 1'b1) begin
         hits++;
      end
      if (cyc == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
      #1;
      rd_v = rdata_out;
   endtask : rd

   task automatic cw(input int n);
      repeat (n) @(posedge sys_clk_in);
      #1;
   endtask : cw

   // Polls the state field until RUN shows, within a bounded number of reads.
   task automatic wait_run(input int lim);
      for (int i = 0; i < lim; i++) begin
         rd(ADDR_STAT);
         if (rd_v[5:2] === 4'h0) break;
      end
   endtask : wait_run

   task automatic wrap_up();
      if (num_errors == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   initial begin
      // Refusal table: speed over the range limit, wrong source in range 3, range too low.
      steps = '{
         '{ADDR_CTRL, 18'h3, RANGE_3, 16'h07d0, 2'h0}, '{ADDR_CLK, 18'h4e20, RANGE_3, 16'h07d0, 2'h0},
         '{ADDR_CLK, 18'h1f41, RANGE_3, 16'h07d0, 2'h0}, '{ADDR_CTRL, 18'h1, RANGE_1, 16'h07d0, 2'h0},
         '{ADDR_CLK, 18'h1f401, RANGE_1, 16'h7d00, 2'h1}, '{ADDR_CLK, 18'h1f405, RANGE_1, 16'h7d00, 2'h1},
         '{ADDR_CTRL, 18'h2, RANGE_1, 16'h7d00, 2'h1}, '{ADDR_CLK, 18'hfa01, RANGE_1, 16'h3e80, 2'h1},
         '{ADDR_CTRL, 18'h2, RANGE_2, 16'h3e80, 2'h1}, '{ADDR_CLK, 18'hfa05, RANGE_2, 16'h3e80, 2'h1},
         '{ADDR_CTRL, 18'h3, RANGE_2, 16'h3e80, 2'h1}, '{ADDR_CLK, 18'h20c, RANGE_2, 16'h0083, 2'h0}};
      {num_errors, n_tests, cyc, hits} = '0;
      {wr_in, rd_in, addr_in, wdata_in} = '0;
      boot_pins_in = 2'b01;
      bor_level_in = 3'h4;
      rst_in = 1'b1;
      repeat (10) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      cw(5);
      chk(boot_src, BOOT_SYSMEM);
      chk(ldr, 2'b11);
      chk(bor_lvl, 3'h4);
      chk(reg_mode, REG_MAIN);
      foreach (steps[i]) begin
         wr(steps[i].a, 32'(steps[i].d));
         cw(1);
         chk({vos, src, khz}, {steps[i].er, steps[i].es, steps[i].ek});
      end
      rd(ADDR_STAT);
      chk(rd_v[0], 1'b1);
      rd(ADDR_CLK);
      chk(rd_v, 32'h20c);
      cw(1);
      chk(rdata_out, 32'h0);
      wr(ADDR_MODE, 32'(MODE_LPRUN));
      rd(ADDR_STAT);
      chk(rd_v[5:2], 4'h0);
      wr(ADDR_STAT, 32'h1);
      wr(ADDR_CLK, 32'h190);
      wr(ADDR_WMASK, 32'h0008_0008);
      wr(ADDR_MODE, 32'(MODE_LPRUN));
      cw(3);
      chk({reg_mode, fast_en}, {REG_LP, 4'h1});
      wr(ADDR_MODE, 32'(MODE_SLEEP));
      cw(3);
      chk({cpu_en, per_en, reg_mode}, {2'b01, REG_LP});
      far.pulse(3, 4);
      wait_run(20);
      chk({rd_v[5:2], reg_mode}, {4'h0, REG_MAIN});
      wr(ADDR_MODE, 32'(MODE_SLEEP));
      cw(3);
      chk({cpu_en, per_en, reg_mode}, {2'b01, REG_MAIN});
      far.pulse(16, 2);
      cw(2);
      chk(cpu_en, 1'b1);
      wr(ADDR_CTRL, 32'he);
      cw(1);
      chk(vref_en, 1'b1);
      wr(ADDR_MODE, 32'(MODE_STOP_RTC));
      cw(3);
      chk({fast_en, slow_en, cpu_en, vref_en, reg_mode}, {4'h0, 3'b100, REG_LP});
      far.pulse(17, 4);
      cw(6);
      rd(ADDR_STAT);
      chk(rd_v[5:2], 4'h5);
      t0 = cyc;
      far.pulse(3, 4);
      wait_run(45);
      chk({rd_v[5:2], vref_en}, {4'h0, 1'b1});
      chk((cyc - t0) <= 84, 1'b1);
      wr(ADDR_MODE, 32'(MODE_STOP_NORTC));
      cw(3);
      chk({fast_en, slow_en, reg_mode}, {5'h00, REG_LP});
      far.pulse(18, 4);
      wait_run(45);
      chk(rd_v[5:2], 4'h0);
      wr(ADDR_MODE, 32'(MODE_STANDBY));
      cw(3);
      chk({reg_mode, core_rst, slow_en}, {REG_PDN, 2'b11});
      far.pulse(3, 4);
      cw(90);
      chk({reg_mode, core_rst}, {REG_MAIN, 1'b0});
      far.level(3, 1'b1);
      cw(3);
      wr(ADDR_MODE, 32'(MODE_STOP_RTC));
      cw(4);
      rd(ADDR_STAT);
      chk({rd_v[5:2], fast_en}, {4'h0, 4'h1});
      far.level(3, 1'b0);
      wr(ADDR_WMASK, 32'h2_0000);
      wr(ADDR_CTRL, 32'he);
      wr(ADDR_MODE, 32'(MODE_STOP_RTC));
      far.pulse(22, 4);
      cw(6);
      rd(ADDR_STAT);
      chk(rd_v[5:2], 4'h5);
      wr(ADDR_CTRL, 32'h6);
      far.pulse(22, 4);
      wait_run(45);
      chk(rd_v[5:2], 4'h0);
      for (k = 0; k < 7; k++) begin
         wr(ADDR_CTRL, 32'h12 | (32'(k) << CTRL_PVD_LVL));
         cw(1);
         chk({pvd_en, pvd_lvl}, {1'b1, 3'(k)});
      end
      wr(ADDR_CTRL, 32'h1b2);
      hits = 0;
      far.level(19, 1'b1);
      cw(8);
      far.level(19, 1'b0);
      cw(8);
      chk(hits, 1);
      wr(ADDR_CTRL, 32'h3b2);
      far.level(19, 1'b1);
      cw(8);
      far.level(19, 1'b0);
      cw(8);
      chk(hits, 3);
      for (k = 20; k < 22; k++) begin
         far.level(k, 1'b1);
         cw(4);
         chk(core_rst, 1'b1);
         far.level(k, 1'b0);
         cw(4);
         chk(core_rst, 1'b0);
      end
      wrap_up();
   end
endmodule : lpm_ctrl_tb_top
